/* File: socket_card_model.sv */
// card side model: interrupt and ring lines for two sockets
// assumes level commands from the bench, launched on the host clock
`timescale 1ns/10ps
module socket_card_model (
	input  wire logic       clk,
	input  wire logic [1:0] irq_cmd,
	input  wire logic [1:0] ring_cmd,
	output logic      [1:0] irq_pin,
	output logic      [1:0] ring_pin
);
	always_ff @(posedge clk) begin
		irq_pin  <= irq_cmd;
		ring_pin <= ring_cmd;
	end
endmodule

/* File: socket_ctl_pkg.sv */
// constants for the per-socket power and interrupt/general control registers
// assumes one host clock and a byte-wide register port
package socket_ctl_pkg;
	localparam int          NUM_SOCKETS       = 2;
	// index space: socket 1 copy sits one stride above socket 0
	localparam logic [7:0]  IDX_POWER         = 8'h02;
	localparam logic [7:0]  IDX_INTGEN        = 8'h03;
	localparam logic [7:0]  IDX_SOCKET_STRIDE = 8'h40;
	// memory space offset from the socket register base
	localparam logic [11:0] MEM_INTGEN        = 12'h803;
	localparam logic        SPACE_INDEX       = 1'b0;
	localparam logic        SPACE_MEMORY      = 1'b1;
	// power register layout
	localparam int          POW_OE_BIT        = 7;
	localparam int          POW_VCC_LSB       = 3;
	localparam int          POW_VPP_LSB       = 0;
	localparam logic [7:0]  POW_WRITE_MASK    = 8'h9b;
	localparam logic [7:0]  POW_RESET         = 8'h00;
	// interrupt and general control layout
	localparam int          IG_RING_BIT       = 7;
	localparam int          IG_RESET_BIT      = 6;
	localparam int          IG_KIND_BIT       = 5;
	localparam int          IG_ROUTE_BIT      = 4;
	localparam int          IG_SEL_LSB        = 0;
	localparam logic [7:0]  IG_RESET          = 8'h00;
	// supply and programming voltage codes
	localparam logic [1:0]  VCC_OFF           = 2'b00;
	localparam logic [1:0]  VCC_5V            = 2'b10;
	localparam logic [1:0]  VCC_3V            = 2'b11;
	localparam logic [1:0]  VPP_OFF           = 2'b00;
	localparam logic [1:0]  VPP_VCC           = 2'b01;
	localparam logic [1:0]  VPP_12V           = 2'b10;
	// interrupt select codes
	localparam logic [3:0]  IRQ_SEL_NONE      = 4'h0;
	localparam logic [3:0]  IRQ_SEL_SMI       = 4'h2;
	localparam logic [7:0]  RDATA_RESET       = 8'h00;
endpackage

/* File: socket_ctl_props.sv */
// assertions on the socket power and interrupt control ports
// assumes it is bound to the block and sees one clock domain
`timescale 1ns/10ps
module socket_ctl_props (
	input wire logic        CLK,
	input wire logic        RST_B,
	input wire logic        REG_RD,
	input wire logic        REG_SPACE,
	input wire logic [11:0] REG_ADDR,
	input wire logic [7:0]  REG_RDATA,
	input wire logic [1:0]  CARD_IS_32BIT,
	input wire logic [3:0]  CARD_SUPPLY_REQUEST,
	input wire logic [3:0]  PROGRAM_VOLTAGE_REQUEST,
	input wire logic [1:0]  SOCKET_POWER_ON_FLAG,
	input wire logic [1:0]  CARD_RESET,
	input wire logic [1:0]  RING_INDICATE_ENABLE,
	input wire logic [1:0]  RING_INDICATE,
	input wire logic [15:0] IRQ_LINES
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_B);
	sequence rd_pow;
		REG_RD && !REG_SPACE && REG_ADDR[5:0] == 6'h02;
	endsequence
	sequence on32;
		CARD_IS_32BIT[0] [*3];
	endsequence
	sequence ring_off;
		!RING_INDICATE_ENABLE[1] [*3];
	endsequence
	AST_RSVD: assert property (
		rd_pow |=> (REG_RDATA & 8'h64) == 8'h00)
		else $error("reserved power bits read back set");
	AST_VCC: assert property (
		CARD_SUPPLY_REQUEST[1:0] != 2'b01 && CARD_SUPPLY_REQUEST[3:2] != 2'b01)
		else $error("reserved supply code driven");
	AST_VPP: assert property (
		PROGRAM_VOLTAGE_REQUEST[3:2] != 2'b11)
		else $error("reserved programming code driven");
	AST_VPP_OFF: assert property (
		!CARD_SUPPLY_REQUEST[3] |-> PROGRAM_VOLTAGE_REQUEST[3:2] == 2'b00)
		else $error("programming voltage without supply");
	AST_PWR_FLAG: assert property (
		SOCKET_POWER_ON_FLAG == {CARD_SUPPLY_REQUEST[3], CARD_SUPPLY_REQUEST[1]})
		else $error("power flag disagrees with supply");
	AST_RST_32: assert property (
		on32 |-> !CARD_RESET[0])
		else $error("reset driven to a 32-bit card");
	AST_RING: assert property (
		ring_off |-> !RING_INDICATE[1])
		else $error("ring shown while disabled");
	AST_IRQ: assert property (
		IRQ_LINES[0] == 1'b0 && IRQ_LINES[2] == 1'b0)
		else $error("unused legacy line driven");
endmodule

bind socket_power_irq_control socket_ctl_props u_props (
	.CLK, .RST_B, .REG_RD, .REG_SPACE, .REG_ADDR, .REG_RDATA, .CARD_IS_32BIT,
	.CARD_SUPPLY_REQUEST, .PROGRAM_VOLTAGE_REQUEST, .SOCKET_POWER_ON_FLAG, .CARD_RESET,
	.RING_INDICATE_ENABLE, .RING_INDICATE, .IRQ_LINES);

/* File: socket_power_irq_control.sv */
// per-socket power control and interrupt/general control registers for two sockets
// assumes a same-clock register port; card pins arrive asynchronously
`timescale 1ns/10ps

// How it works
// - bit 7 drives the 16-bit socket output enable, CARD_OUTPUT_ENABLE
// - power bits 6-5 and 2 read zero
// - bits 4-3 pick supply: off, 5V, 3V
// - bits 1-0 pick programming voltage
// - programming voltage ignored unless supply on
// - bit 7 turns battery pin into ring
// - bit 6 low holds 16-bit card reset
// - bit 5 marks memory or I/O card
// - bit 4 sends status change to bus
// - bits 3-0 route card functional interrupt
// - second socket copy sits 40h higher
// - control register also at base plus 803h
// - power-on flag follows programmed supply
// - unrouted status change uses its select field
module socket_power_irq_control (
	input  wire logic                                         CLK,
	input  wire logic                                         RST_B,
	input  wire logic                                         REG_WR,
	input  wire logic                                         REG_RD,
	input  wire logic                                         REG_SPACE,
	input  wire logic                                         REG_SOCKET,
	input  wire logic [11:0]                                  REG_ADDR,
	input  wire logic [7:0]                                   REG_WDATA,
	output logic      [7:0]                                   REG_RDATA,
	input  wire logic [socket_ctl_pkg::NUM_SOCKETS-1:0]       BATTERY_DETECT1_RING_PIN,
	input  wire logic [socket_ctl_pkg::NUM_SOCKETS-1:0]       CARD_IRQ_PIN,
	input  wire logic [socket_ctl_pkg::NUM_SOCKETS-1:0]       CARD_IS_32BIT,
	input  wire logic [socket_ctl_pkg::NUM_SOCKETS-1:0]       STATUS_CHANGE_EVENT,
	input  wire logic [4*socket_ctl_pkg::NUM_SOCKETS-1:0]     STATUS_CHANGE_IRQ_SELECT,
	output logic      [socket_ctl_pkg::NUM_SOCKETS-1:0]       CARD_OUTPUT_ENABLE,
	output logic      [2*socket_ctl_pkg::NUM_SOCKETS-1:0]     CARD_SUPPLY_REQUEST,
	output logic      [2*socket_ctl_pkg::NUM_SOCKETS-1:0]     PROGRAM_VOLTAGE_REQUEST,
	output logic      [socket_ctl_pkg::NUM_SOCKETS-1:0]       SOCKET_POWER_ON_FLAG,
	output logic      [socket_ctl_pkg::NUM_SOCKETS-1:0]       CARD_RESET,
	output logic      [socket_ctl_pkg::NUM_SOCKETS-1:0]       SOCKET_CARD_KIND,
	output logic      [socket_ctl_pkg::NUM_SOCKETS-1:0]       RING_INDICATE_ENABLE,
	output logic      [socket_ctl_pkg::NUM_SOCKETS-1:0]       RING_INDICATE,
	output logic      [socket_ctl_pkg::NUM_SOCKETS-1:0]       BATTERY_DETECT1,
	output logic      [socket_ctl_pkg::NUM_SOCKETS-1:0]       BUS_INT,
	output logic      [15:0]                                  IRQ_LINES,
	output logic                                              SMI
);
	import socket_ctl_pkg::*;

	typedef logic [7:0] byte_t;

	byte_t                       power_r  [NUM_SOCKETS];
	byte_t                       intgen_r [NUM_SOCKETS];
	logic [NUM_SOCKETS-1:0]      bvd_meta_r;
	logic [NUM_SOCKETS-1:0]      bvd_sync_r;
	logic [NUM_SOCKETS-1:0]      irq_meta_r;
	logic [NUM_SOCKETS-1:0]      irq_sync_r;
	logic                        hit;
	logic                        hit_intgen;
	logic                        hit_sock;
	logic [15:0]                 lines_nxt;
	logic                        smi_nxt;
	logic [NUM_SOCKETS-1:0]      bus_nxt;

	// address decode: {hit, selects intgen, socket}
	function automatic logic [2:0] decode(input logic space, input logic sock,
		input logic [11:0] addr);
		logic [2:0] res;
		res = 3'b000;
		if (space == SPACE_MEMORY) begin
			if (addr == MEM_INTGEN)
				res = {1'b1, 1'b1, sock};
		end else if (addr[11:8] == 4'h0) begin
			// index 00h-3fh socket 0, 40h-7fh socket 1
			if ((addr[7:0] & ~IDX_SOCKET_STRIDE) == IDX_POWER)
				res = {1'b1, 1'b0, addr[6]};
			else if ((addr[7:0] & ~IDX_SOCKET_STRIDE) == IDX_INTGEN)
				res = {1'b1, 1'b1, addr[6]};
		end
		return res;
	endfunction

	// select code to {smi, legacy lines}; line 2 is never a legacy target
	function automatic logic [16:0] route(input logic [3:0] sel, input logic req);
		logic [16:0] res;
		res = 17'h00000;
		if (req && sel == IRQ_SEL_SMI)
			res[16] = 1'b1;
		else if (req && sel != IRQ_SEL_NONE)
			res[sel] = 1'b1;
		return res;
	endfunction

	function automatic logic supply_on(input logic [1:0] vcc);
		return (vcc == VCC_5V) || (vcc == VCC_3V);
	endfunction

	assign {hit, hit_intgen, hit_sock} = decode(REG_SPACE, REG_SOCKET, REG_ADDR);

	// two-flop synchronisers for the card pins
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			bvd_meta_r <= '0;
			bvd_sync_r <= '0;
			irq_meta_r <= '0;
			irq_sync_r <= '0;
		end else begin
			bvd_meta_r <= BATTERY_DETECT1_RING_PIN;
			bvd_sync_r <= bvd_meta_r;
			irq_meta_r <= CARD_IRQ_PIN;
			irq_sync_r <= irq_meta_r;
		end
	end

	// register writes
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			for (int s = 0; s < NUM_SOCKETS; s++) begin
				power_r[s]  <= POW_RESET;
				intgen_r[s] <= IG_RESET;
			end
		end else if (REG_WR && hit) begin
			if (hit_intgen)
				intgen_r[hit_sock] <= REG_WDATA;
			else
				power_r[hit_sock] <= REG_WDATA & POW_WRITE_MASK;
		end
	end

	// register reads, one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			REG_RDATA <= RDATA_RESET;
		end else if (REG_RD) begin
			if (!hit)
				REG_RDATA <= RDATA_RESET;
			else if (hit_intgen)
				REG_RDATA <= intgen_r[hit_sock];
			else
				REG_RDATA <= power_r[hit_sock] & POW_WRITE_MASK;
		end
	end

	// power outputs
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			CARD_OUTPUT_ENABLE      <= '0;
			CARD_SUPPLY_REQUEST     <= '0;
			PROGRAM_VOLTAGE_REQUEST <= '0;
			SOCKET_POWER_ON_FLAG    <= '0;
		end else begin
			for (int s = 0; s < NUM_SOCKETS; s++) begin
				logic [1:0] vcc;
				logic [1:0] vpp;
				vcc = power_r[s][POW_VCC_LSB +: 2];
				vpp = power_r[s][POW_VPP_LSB +: 2];
				CARD_OUTPUT_ENABLE[s] <= power_r[s][POW_OE_BIT];
				// reserved supply code 01 falls back to off
				CARD_SUPPLY_REQUEST[2*s +: 2] <= supply_on(vcc) ? vcc : VCC_OFF;
				SOCKET_POWER_ON_FLAG[s] <= supply_on(vcc);
				if (!supply_on(vcc))
					PROGRAM_VOLTAGE_REQUEST[2*s +: 2] <= VPP_OFF;
				else if (vpp == VPP_VCC || vpp == VPP_12V)
					PROGRAM_VOLTAGE_REQUEST[2*s +: 2] <= vpp;
				else
					PROGRAM_VOLTAGE_REQUEST[2*s +: 2] <= VPP_OFF;
			end
		end
	end

	// card control outputs; reset starts asserted
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			CARD_RESET           <= '1;
			SOCKET_CARD_KIND     <= '0;
			RING_INDICATE_ENABLE <= '0;
			RING_INDICATE        <= '0;
			BATTERY_DETECT1      <= '0;
		end else begin
			for (int s = 0; s < NUM_SOCKETS; s++) begin
				// 32-bit cards drop the 16-bit reset from the next clock; RST_B low asserts it on every socket
				CARD_RESET[s] <= !CARD_IS_32BIT[s] && !intgen_r[s][IG_RESET_BIT];
				SOCKET_CARD_KIND[s]     <= intgen_r[s][IG_KIND_BIT];
				RING_INDICATE_ENABLE[s] <= intgen_r[s][IG_RING_BIT];
				RING_INDICATE[s]   <= intgen_r[s][IG_RING_BIT] && bvd_sync_r[s];
				BATTERY_DETECT1[s] <= !intgen_r[s][IG_RING_BIT] && bvd_sync_r[s];
			end
		end
	end

	// interrupt routing, combined over both sockets
	always_comb begin
		logic [16:0] r;
		r         = 17'h00000;
		lines_nxt = 16'h0000;
		smi_nxt   = 1'b0;
		bus_nxt   = '0;
		for (int s = 0; s < NUM_SOCKETS; s++) begin
			// functional interrupt only from I/O cards
			r = route(intgen_r[s][IG_SEL_LSB +: 4],
				irq_sync_r[s] && intgen_r[s][IG_KIND_BIT]);
			lines_nxt = lines_nxt | r[15:0];
			smi_nxt   = smi_nxt | r[16];
			if (intgen_r[s][IG_ROUTE_BIT]) begin
				bus_nxt[s] = STATUS_CHANGE_EVENT[s];
			end else begin
				r = route(STATUS_CHANGE_IRQ_SELECT[4*s +: 4],
					STATUS_CHANGE_EVENT[s]);
				lines_nxt = lines_nxt | r[15:0];
				smi_nxt   = smi_nxt | r[16];
			end
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			IRQ_LINES <= 16'h0000;
			SMI       <= 1'b0;
			BUS_INT   <= '0;
		end else begin
			IRQ_LINES <= lines_nxt;
			SMI       <= smi_nxt;
			BUS_INT   <= bus_nxt;
		end
	end
endmodule

/* File: socket_power_irq_control_test.sv */
// bench for the socket power and interrupt control registers
// assumes the card model on the far side and a 100 MHz clock
`timescale 1ns/10ps
module socket_power_irq_control_test;
	logic        clk, rst_b, wr, rd, sp, so, smi;
	logic [11:0] addr;
	logic [7:0]  wd, rdata, sel, d;
	logic [1:0]  is32, evt, icmd, rcmd, rpin, ipin, oe, pon, crst, kind, rien, ri, bd1, bint;
	logic [1:0]  ev, ep;
	logic [3:0]  vcc, vpp;
	logic [15:0] irq;
	int          n_errors, samples_checked;
	socket_card_model card (.clk(clk), .irq_cmd(icmd), .ring_cmd(rcmd), .irq_pin(ipin),
		.ring_pin(rpin));
	socket_power_irq_control uut (.CLK(clk), .RST_B(rst_b), .REG_WR(wr), .REG_RD(rd),
		.REG_SPACE(sp), .REG_SOCKET(so), .REG_ADDR(addr), .REG_WDATA(wd), .REG_RDATA(rdata),
		.BATTERY_DETECT1_RING_PIN(rpin), .CARD_IRQ_PIN(ipin), .CARD_IS_32BIT(is32),
		.STATUS_CHANGE_EVENT(evt), .STATUS_CHANGE_IRQ_SELECT(sel), .CARD_OUTPUT_ENABLE(oe),
		.CARD_SUPPLY_REQUEST(vcc), .PROGRAM_VOLTAGE_REQUEST(vpp), .SOCKET_POWER_ON_FLAG(pon),
		.CARD_RESET(crst), .SOCKET_CARD_KIND(kind), .RING_INDICATE_ENABLE(rien),
		.RING_INDICATE(ri), .BATTERY_DETECT1(bd1), .BUS_INT(bint), .IRQ_LINES(irq), .SMI(smi));
	task check(input logic [17:0] s, input logic [17:0] e);
		samples_checked++;
		if (s !== e) begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// one register access, then time for outputs and read data to settle
	task acc(input logic w, input logic [11:0] a, input logic [7:0] v);
		@(posedge clk);
		wr <= w;
		rd <= !w;
		sp <= a[11];
		addr <= a;
		wd <= v;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
	endtask
	task test_done;
		if (n_errors == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	initial begin
		#100000;
		n_errors++;
		test_done();
	end
	initial begin
		{rst_b, wr, rd, sp, so, is32, evt, icmd, rcmd, addr, wd, sel} = '0;
		n_errors = 0;
		samples_checked = 0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		#1;
		check({oe, pon, crst, vcc, vpp}, 14'h0300);
		for (int i = 0; i < 4; i++) begin
			acc(0, 12'h002 + 12'(i % 2) + 12'(i / 2 * 64), 0);
			check(rdata, 0);
		end
		for (int v = 0; v < 16; v++) begin
			d = {3'b111, v[3:2], 1'b1, v[1:0]};
			acc(1, 12'h042, d);
			ev = v[3:2] == 2'b01 ? 2'b00 : v[3:2];
			ep = (!v[3] || v[1:0] == 2'b11) ? 2'b00 : v[1:0];
			check({vcc, pon, oe}, {ev, 2'b00, v[3], 3'b010});
			check(vpp, {ep, 2'b00});
			acc(0, 12'h042, 0);
			check(rdata, d & 8'h9b);
		end
		acc(1, 12'h042, 8'h7f);
		check(oe, 0);
		@(posedge clk) rcmd <= 2'b10;
		acc(1, 12'h043, 8'hc0);
		check({rien, crst, ri, bd1}, 8'b10_01_10_00);
		acc(1, 12'h803, 8'h60);
		acc(0, 12'h003, 0);
		check(rdata, 8'h60);
		check({kind, crst}, 4'b0100);
		@(posedge clk) is32 <= 2'b01;
		acc(1, 12'h803, 8'h20);
		check(crst, 0);
		@(posedge clk) is32 <= 2'b00;
		icmd <= 2'b01;
		for (int s = 0; s < 16; s++) begin
			acc(1, 12'h803, 8'h20 | 8'(s));
			check({smi, irq}, (s == 0) ? 0 : (s == 2) ? 17'h10000 : 17'h1 << s);
		end
		check(crst, 2'b01);
		@(posedge clk) icmd <= 2'b00;
		sel <= 8'h50;
		acc(1, 12'h043, 8'h10);
		@(posedge clk) evt <= 2'b10;
		repeat (3) @(posedge clk);
		#1;
		check({bint, irq}, {2'b10, 16'h0000});
		check(bd1, 2'b10);
		acc(1, 12'h043, 8'h00);
		check({bint, irq}, {2'b00, 16'h0020});
		acc(1, 12'h005, 8'hff);
		acc(0, 12'h005, 0);
		check(rdata, 0);
		@(posedge clk) so <= 1'b1;
		acc(1, 12'h803, 8'h40);
		acc(0, 12'h043, 0);
		check(rdata, 8'h40);
		test_done();
	end
endmodule
